// ==== src/wrdl_pkg.sv ====
// Package: register map, field layout and constants of the working-register block
package wrdl_pkg;
   localparam int WRDL_WORD_W = 36;
   localparam int WRDL_NUM_W  = 32;
   localparam int WRDL_STO_N  = 12;
   localparam int WRDL_STO_BASE_N = 6;
   localparam int WRDL_DL_N   = 14;
   localparam int WRDL_ADDR_W = 6;

   // Register addresses (word index on the plain port)
   localparam logic [5:0] WRDL_A_ACC    = 6'h00;
   localparam logic [5:0] WRDL_A_OPB    = 6'h01;
   localparam logic [5:0] WRDL_A_FLAG1  = 6'h02;
   localparam logic [5:0] WRDL_A_FLAG2  = 6'h03;
   localparam logic [5:0] WRDL_A_GRPSEL = 6'h04;
   localparam logic [5:0] WRDL_A_FLAGOP = 6'h05;
   localparam logic [5:0] WRDL_A_DL     = 6'h06;
   localparam logic [5:0] WRDL_A_KOUT   = 6'h07;
   localparam logic [5:0] WRDL_A_KIN    = 6'h08;
   localparam logic [5:0] WRDL_A_OPDONE = 6'h09;
   localparam logic [5:0] WRDL_A_EXT    = 6'h0A;
   localparam logic [5:0] WRDL_A_SCRATCH_STORE_ZERO   = 6'h10;

   // Flag-op word fields: [3:0] index, [5:4] op
   localparam int WRDL_FOP_IDX_LSB = 0;
   localparam int WRDL_FOP_CMD_LSB = 4;
   localparam logic [1:0] WRDL_FOP_SET   = 2'h1;
   localparam logic [1:0] WRDL_FOP_CLEAR = 2'h2;
   localparam logic [1:0] WRDL_FOP_TEST  = 2'h3;

   // Op-done word fields: [1:0] kind
   localparam logic [1:0] WRDL_OP_MUL  = 2'h1;
   localparam logic [1:0] WRDL_OP_HEX  = 2'h2;
   localparam logic [1:0] WRDL_OP_DIV  = 2'h3;

   // Digit-latch positions
   localparam int WRDL_DL_ECLK  = 0;
   localparam int WRDL_DL_EPWR  = 7;
   localparam int WRDL_DL_KDIR  = 8;
   localparam int WRDL_DL_AS0   = 9;
   localparam int WRDL_DL_TICK  = 12;
   localparam int WRDL_DL_ISRC  = 13;
   localparam logic [13:0] WRDL_DL_SW_MASK = 14'h3F7E;

   // Group-one predefined flag positions
   localparam int WRDL_FG_SEGH_LSB = 1;
   localparam int WRDL_FG_LONGT    = 10;
   localparam int WRDL_FG_SHORTT   = 11;
   localparam int WRDL_FG_KBUF_LSB = 12;

   localparam logic [35:0] WRDL_RST_WORD = 36'h000000000;
   localparam logic [15:0] WRDL_RST_FLAG = 16'h0000;
   localparam logic [13:0] WRDL_RST_DL   = 14'h0000;
   localparam logic [3:0]  WRDL_RST_K    = 4'h0;

   typedef enum logic [3:0] {
      WRDL_AIN_ONE   = 4'h1,
      WRDL_AIN_TWO   = 4'h2,
      WRDL_AIN_THREE = 4'h4,
      WRDL_AIN_FOUR  = 4'h8
   } wrdl_ain_t;
endpackage

// ==== src/wrdl_kport.sv ====
// Four-line open-source port with output latch, direction and wake detect
`timescale 1ns/1ps
module wrdl_kport (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       dir_out,
   input  wire logic [3:0] kout,
   input  wire logic [3:0] pin_in,
   input  wire logic       low_power,
   output logic [3:0]      pin_o,
   output logic [3:0]      pin_oe,
   output logic [3:0]      kin_ff,
   output logic            wake_ff
);
   import wrdl_pkg::*;

   logic [3:0] prev_ff;
   wire  [3:0] nxt_oe  = dir_out ? kout : 4'h0;
   wire        nxt_wake = low_power && (pin_in != prev_ff);

   // Open source: only the high level is driven, a 0 leaves the line floating
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_o   <= 4'h0;
         pin_oe  <= 4'h0;
         kin_ff  <= WRDL_RST_K;
         prev_ff <= WRDL_RST_K;
         wake_ff <= 1'b0;
      end else begin
         pin_o   <= 4'hF;
         pin_oe  <= nxt_oe;
         kin_ff  <= pin_in;
         prev_ff <= pin_in;
         wake_ff <= nxt_wake;
      end
   end
endmodule

// ==== src/wrdl_top.sv ====
// Working registers, storage bank, flag groups and digit latches
`timescale 1ns/1ps
module wrdl_top (
   input  wire logic                         clk_sys,
   input  wire logic                         arst_n,
   input  wire logic [wrdl_pkg::WRDL_ADDR_W-1:0] addr,
   input  wire logic [35:0]                  wdata,
   input  wire logic                         wr_stb,
   input  wire logic                         rd_stb,
   input  wire logic [35:0]                  result_data,
   input  wire logic                         result_we,
   input  wire logic [35:0]                  remainder,
   input  wire logic                         eeprom_clock_drive,
   input  wire logic                         eeprom_power_drive,
   input  wire logic                         tick_1hz,
   input  wire logic                         tick_16hz,
   input  wire logic                         long_timer_evt,
   input  wire logic                         short_timer_evt,
   input  wire logic                         sensor_supply_on,
   input  wire logic                         low_power,
   input  wire logic [3:0]                   port_in,
   output logic [35:0]                       rdata,
   output logic [35:0]                       main_accumulator,
   output logic                              flag_test_ff,
   output logic [5:0]                        general_outputs,
   output logic                              eeprom_clock_out,
   output logic                              eeprom_power_out,
   output logic [3:0]                        analog_route,
   output logic                              battery_check,
   output logic                              timer_tick,
   output logic                              current_source_on,
   output logic [6:0]                        segment_h,
   output logic [3:0]                        port_o,
   output logic [3:0]                        port_oe,
   output logic                              wake_up
);
   import wrdl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rs1_ff;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rs1_ff <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rs1_ff <= 1'b1;
         rst_n  <= rs1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
      hit = (a == r);
   endfunction

   logic        ext_ff;
   logic        grp_ff;
   wire  [5:0]  sto_rel  = addr - WRDL_A_SCRATCH_STORE_ZERO;
   wire         sto_rng  = (addr >= WRDL_A_SCRATCH_STORE_ZERO) &&
                           (sto_rel < 6'(WRDL_STO_N));
   wire         sto_ok   = sto_rng &&
                           (ext_ff || sto_rel < 6'(WRDL_STO_BASE_N));
   wire  [3:0]  sto_idx  = sto_rel[3:0];
   wire         w_acc    = wr_stb && hit(addr, WRDL_A_ACC);
   wire         w_opb    = wr_stb && hit(addr, WRDL_A_OPB);
   wire         w_f1     = wr_stb && hit(addr, WRDL_A_FLAG1);
   wire         w_f2     = wr_stb && hit(addr, WRDL_A_FLAG2);
   wire         w_grp    = wr_stb && hit(addr, WRDL_A_GRPSEL);
   wire         w_fop    = wr_stb && hit(addr, WRDL_A_FLAGOP);
   wire         w_dl     = wr_stb && hit(addr, WRDL_A_DL);
   wire         w_kout   = wr_stb && hit(addr, WRDL_A_KOUT);
   wire         w_done   = wr_stb && hit(addr, WRDL_A_OPDONE);
   wire         w_ext    = wr_stb && hit(addr, WRDL_A_EXT);
   wire         w_sto    = wr_stb && sto_ok;

   ////////////////////////////////////////////////////////////////////////
   // Working registers
   logic [35:0] acc_ff;
   logic [35:0] opb_ff;
   wire  [35:0] nxt_acc = result_we ? result_data : wdata;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= WRDL_RST_WORD;
         opb_ff <= WRDL_RST_WORD;
      end else begin
         if (result_we || w_acc)
            acc_ff <= nxt_acc;
         if (w_opb)
            opb_ff <= wdata;
      end
   end

   // Extended-bank prefix: one-shot, consumed by the next storage access
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         ext_ff <= 1'b0;
      else if (w_ext)
         ext_ff <= wdata[0];
      else if ((wr_stb || rd_stb) && sto_rng)
         ext_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage bank
   logic [35:0] sto_ff [WRDL_STO_N];
   wire  [1:0]  done_k = wdata[1:0];
   wire         clr0   = w_done &&
                         (done_k == WRDL_OP_MUL || done_k == WRDL_OP_HEX);
   wire         rem0   = w_done && (done_k == WRDL_OP_DIV);

   genvar gi;
   generate
      for (gi = 0; gi < WRDL_STO_N; gi++) begin : g_sto
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n)
               sto_ff[gi] <= WRDL_RST_WORD;
            else if (gi == 0 && clr0)
               sto_ff[gi] <= WRDL_RST_WORD;
            else if (gi == 0 && rem0)
               sto_ff[gi] <= remainder;
            else if (w_sto && sto_idx == 4'(gi))
               sto_ff[gi] <= wdata;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Flag groups
   logic [15:0] f1_ff;
   logic [15:0] f2_ff;
   logic [13:0] dl_ff;
   logic [3:0]  kout_ff;
   logic [3:0]  kin;
   logic        kwake;
   wire  [3:0]  fidx   = wdata[WRDL_FOP_IDX_LSB +: 4];
   wire  [1:0]  fcmd   = wdata[WRDL_FOP_CMD_LSB +: 2];
   wire  [15:0] fbit   = 16'h0001 << fidx;
   wire         f_set  = w_fop && fcmd == WRDL_FOP_SET;
   wire         f_clr  = w_fop && fcmd == WRDL_FOP_CLEAR;
   wire         f_tst  = w_fop && fcmd == WRDL_FOP_TEST;
   wire  [15:0] cur_f  = grp_ff ? f2_ff : f1_ff;
   // Hardware events in group one win over a same-cycle software clear
   wire  [15:0] hw_set = {4'h0, short_timer_evt, long_timer_evt, 10'h000};
   wire  [15:0] f1_wr  = w_f1 ? wdata[15:0] : f1_ff;
   wire  [15:0] f1_op  = (!grp_ff && f_set) ? (f1_wr | fbit) :
                         (!grp_ff && f_clr) ? (f1_wr & ~fbit) : f1_wr;
   wire  [15:0] nxt_f1 = {kin[3:0] & ~{4{dl_ff[WRDL_DL_KDIR]}} |
                          f1_op[15:12] & {4{dl_ff[WRDL_DL_KDIR]}},
                          f1_op[11:0] | hw_set[11:0]};
   wire  [15:0] f2_wr  = w_f2 ? wdata[15:0] : f2_ff;
   wire  [15:0] nxt_f2 = (grp_ff && f_set) ? (f2_wr | fbit) :
                         (grp_ff && f_clr) ? (f2_wr & ~fbit) : f2_wr;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         f1_ff        <= WRDL_RST_FLAG;
         f2_ff        <= WRDL_RST_FLAG;
         grp_ff       <= 1'b0;
         flag_test_ff <= 1'b0;
      end else begin
         f1_ff <= nxt_f1;
         f2_ff <= nxt_f2;
         if (w_grp)
            grp_ff <= wdata[0];
         if (f_tst)
            flag_test_ff <= cur_f[fidx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Digit latches and port output latch
   // Software mask keeps latches zero and seven out of reach
   wire [13:0] nxt_dl_sw = (dl_ff & ~WRDL_DL_SW_MASK) |
                           (wdata[13:0] & WRDL_DL_SW_MASK);
   wire [13:0] nxt_dl_hw = {nxt_dl_sw[13:8], eeprom_power_drive,
                            nxt_dl_sw[6:1], eeprom_clock_drive};
   wire [13:0] dl_sel    = w_dl ? nxt_dl_hw :
                           {dl_ff[13:8], eeprom_power_drive,
                            dl_ff[6:1], eeprom_clock_drive};
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dl_ff   <= WRDL_RST_DL;
         kout_ff <= WRDL_RST_K;
      end else begin
         dl_ff <= dl_sel;
         if (w_kout)
            kout_ff <= wdata[3:0];
      end
   end

   wrdl_kport u_kport (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .dir_out   (dl_ff[WRDL_DL_KDIR]),
      .kout      (kout_ff),
      .pin_in    (port_in),
      .low_power (low_power),
      .pin_o     (port_o),
      .pin_oe    (port_oe),
      .kin_ff    (kin),
      .wake_ff   (kwake)
   );

   ////////////////////////////////////////////////////////////////////////
   // Hardware function decode
   wire [2:0] asel = dl_ff[WRDL_DL_AS0 +: 3];
   // Note bit order: latch nine is the leading bit of the select
   wire [2:0] asel_o = {asel[0], asel[1], asel[2]};
   wire nxt_batt = asel_o[2];
   wire [1:0] ain_lo = asel_o[1:0];
   wrdl_ain_t ain;
   always_comb begin
      case (ain_lo)
         2'b00:   ain = WRDL_AIN_ONE;
         2'b10:   ain = WRDL_AIN_TWO;
         2'b01:   ain = WRDL_AIN_THREE;
         2'b11:   ain = WRDL_AIN_FOUR;
         default: ain = WRDL_AIN_ONE;
      endcase
   end
   // Battery check takes the converter away from all four inputs
   wire [3:0] nxt_route = nxt_batt ? 4'h0 : ain;
   wire nxt_tick = dl_ff[WRDL_DL_TICK] ? tick_16hz : tick_1hz;
   wire nxt_isrc = dl_ff[WRDL_DL_ISRC] && sensor_supply_on;

   ////////////////////////////////////////////////////////////////////////
   // Read port and registered outputs
   logic [35:0] nxt_rd;
   always_comb begin
      nxt_rd = 36'h000000000;
      if (rd_stb) begin
         if (sto_ok)
            nxt_rd = sto_ff[sto_idx];
         else
            case (addr)
               WRDL_A_ACC:    nxt_rd = acc_ff;
               WRDL_A_OPB:    nxt_rd = opb_ff;
               WRDL_A_FLAG1:  nxt_rd = {20'h00000, f1_ff};
               WRDL_A_FLAG2:  nxt_rd = {20'h00000, f2_ff};
               WRDL_A_GRPSEL: nxt_rd = {35'h000000000, grp_ff};
               WRDL_A_DL:     nxt_rd = {22'h000000, dl_ff};
               WRDL_A_KOUT:   nxt_rd = {32'h00000000, kout_ff};
               WRDL_A_KIN:    nxt_rd = {32'h00000000, kin};
               WRDL_A_EXT:    nxt_rd = {35'h000000000, ext_ff};
               default:       nxt_rd = 36'h000000000;
            endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata             <= 36'h000000000;
         main_accumulator  <= WRDL_RST_WORD;
         general_outputs   <= 6'h00;
         eeprom_clock_out  <= 1'b0;
         eeprom_power_out  <= 1'b0;
         analog_route      <= 4'h0;
         battery_check     <= 1'b0;
         timer_tick        <= 1'b0;
         current_source_on <= 1'b0;
         segment_h         <= 7'h00;
         wake_up           <= 1'b0;
      end else begin
         rdata             <= nxt_rd;
         main_accumulator  <= acc_ff;
         general_outputs   <= dl_ff[6:1];
         eeprom_clock_out  <= dl_ff[WRDL_DL_ECLK];
         eeprom_power_out  <= dl_ff[WRDL_DL_EPWR];
         analog_route      <= nxt_route;
         battery_check     <= nxt_batt;
         timer_tick        <= nxt_tick;
         current_source_on <= nxt_isrc;
         segment_h         <= f1_ff[WRDL_FG_SEGH_LSB +: 7];
         wake_up           <= kwake;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_sto_zero_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clr0 |=> sto_ff[0] == 36'h000000000)
      else $error("store zero not cleared");
   a_sto_rem_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rem0 |=> sto_ff[0] == $past(remainder))
      else $error("remainder not loaded");
   a_ext_guard: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && sto_rng && sto_rel >= 6'h06 && !ext_ff)
      |=> sto_ff[$past(sto_idx)] == $past(sto_ff[sto_idx]))
      else $error("extended store written without prefix");
   a_grp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !w_grp |=> $stable(grp_ff))
      else $error("flag group changed without select");
   a_eeprom_sw: assert property (@(posedge clk_sys) disable iff (!rst_n)
      w_dl |=> dl_ff[WRDL_DL_ECLK] == $past(eeprom_clock_drive) &&
               dl_ff[WRDL_DL_EPWR] == $past(eeprom_power_drive))
      else $error("software reached eeprom clock latch");
   a_gen_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 general_outputs == $past(dl_ff[6:1]))
      else $error("general outputs not following latches");
   a_port_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !dl_ff[WRDL_DL_KDIR] |=> port_oe == 4'h0)
      else $error("port driven in input mode");
   a_isrc_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !sensor_supply_on |=> !current_source_on)
      else $error("current source on without supply");
   a_tick_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (dl_ff[WRDL_DL_TICK] && tick_16hz) |=> timer_tick)
      else $error("fast tick not routed");
endmodule

// ==== bench/wrdl_line_model.sv ====
// Far-side model: sensors and pull-downs on the four port lines
`timescale 1ns/1ps
module wrdl_line_model (
   input  wire logic [3:0] port_o,
   input  wire logic [3:0] port_oe,
   input  wire logic       ext_en,
   input  wire logic [3:0] ext_val,
   output logic [3:0]      port_in
);
   ////////////////////////////////////////////////////////////////////////
   // A line is high only where the device sources it or a sensor drives
   // it; a released line falls to its pull-down instead of holding
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         port_in[i] = (port_oe[i] & port_o[i]) |
                      (ext_en & ~port_oe[i] & ext_val[i]);
      end
   end
endmodule

// ==== bench/wrdl_top_tb.sv ====
// Self-checking bench for the working-register and digit-latch block
`timescale 1ns/1ps
module wrdl_top_tb;
   import wrdl_pkg::*;
   logic        clk_sys, arst_n, wr_stb, rd_stb, result_we, low_power;
   logic        eeprom_clock_drive, eeprom_power_drive, tick_1hz, tick_16hz;
   logic        long_timer_evt, short_timer_evt, sensor_supply_on, ext_en;
   logic        flag_test_ff, eeprom_clock_out, eeprom_power_out, wake_up;
   logic        battery_check, timer_tick, current_source_on, w;
   logic [5:0]  addr, general_outputs, a;
   logic [35:0] wdata, result_data, remainder, rdata, main_accumulator, v;
   logic [3:0]  port_in, ext_val, analog_route, port_o, port_oe, kv;
   logic [6:0]  segment_h, sg;
   logic [15:0] fv;
   logic [13:0] d;
   logic [31:0] seed;
   int          failures, cmp_count;
   int          cycles = 0;

   wrdl_top u_wrdl_top (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .result_data(result_data), .result_we(result_we),
      .remainder(remainder), .eeprom_clock_drive(eeprom_clock_drive),
      .eeprom_power_drive(eeprom_power_drive), .tick_1hz(tick_1hz),
      .tick_16hz(tick_16hz), .long_timer_evt(long_timer_evt),
      .short_timer_evt(short_timer_evt),
      .sensor_supply_on(sensor_supply_on), .low_power(low_power),
      .port_in(port_in), .rdata(rdata), .main_accumulator(main_accumulator),
      .flag_test_ff(flag_test_ff), .general_outputs(general_outputs),
      .eeprom_clock_out(eeprom_clock_out),
      .eeprom_power_out(eeprom_power_out), .analog_route(analog_route),
      .battery_check(battery_check), .timer_tick(timer_tick),
      .current_source_on(current_source_on), .segment_h(segment_h),
      .port_o(port_o), .port_oe(port_oe), .wake_up(wake_up));

   wrdl_line_model u_wrdl_line_model (.port_o(port_o), .port_oe(port_oe),
      .ext_en(ext_en), .ext_val(ext_val), .port_in(port_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [35:0] rnd36();
      logic [31:0] t;
      t = rnd();
      return {t[3:0], rnd()};
   endfunction
   function automatic logic [35:0] fop(input logic [1:0] c, input int i);
      return 36'({c, 4'(i)});
   endfunction
   // Leading select bit wins; otherwise the two low bits pick one input
   function automatic logic [3:0] exp_route(input logic [13:0] x);
      if (x[9]) return 4'h0;
      return 4'h1 << {x[11], x[10]};
   endfunction

   task automatic chk(input string nm, input logic [35:0] e,
                      input logic [35:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [5:0] ad, input logic [35:0] dt);
      @(posedge clk_sys);
      addr <= ad;
      wdata <= dt;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] ad, input logic [35:0] e,
                     input string nm);
      @(posedge clk_sys);
      addr <= ad;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   task automatic close_out();
      if (failures == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Cuts a hang short; the whole sequence needs well under this
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {addr, wdata, wr_stb, rd_stb, result_data, result_we, remainder} = '0;
      {eeprom_clock_drive, eeprom_power_drive, tick_1hz, tick_16hz} = '0;
      {long_timer_evt, short_timer_evt, sensor_supply_on, low_power} = '0;
      failures = 0;
      cmp_count = 0;
      seed = 32'h00012A50;
      ext_en = 1'b1;
      ext_val = 4'(rnd());
      arst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      step(2);
      chk("general_outputs", '0, 36'(general_outputs));
      chk("eeprom outs", '0, 36'({eeprom_clock_out, eeprom_power_out}));
      rd(WRDL_A_ACC, WRDL_RST_WORD, "acc reset");
      v = rnd36();
      wr(WRDL_A_ACC, v);
      step(1);
      chk("main_accumulator", v, main_accumulator);
      v = rnd36();
      @(posedge clk_sys);
      result_data <= v;
      result_we <= 1'b1;
      @(posedge clk_sys);
      result_we <= 1'b0;
      rd(WRDL_A_ACC, v, "acc result");
      v = rnd36();
      wr(WRDL_A_OPB, v);
      rd(WRDL_A_OPB, v, "opb");
      // All twelve stores: the upper six refuse plain access, prefixed access works
      for (int i = 0; i < 12; i++) begin
         v = rnd36();
         a = WRDL_A_SCRATCH_STORE_ZERO + 6'(i);
         if (i >= 6) wr(WRDL_A_EXT, 36'h1);
         wr(a, v);
         if (i >= 6) begin
            wr(a, ~v);
            rd(a, '0, "locked store");
            wr(WRDL_A_EXT, 36'h1);
         end
         rd(a, v, "store");
      end
      for (int k = 1; k < 4; k++) begin
         v = rnd36();
         remainder <= v;
         wr(WRDL_A_SCRATCH_STORE_ZERO, ~v);
         wr(WRDL_A_OPDONE, 36'(k));
         rd(WRDL_A_SCRATCH_STORE_ZERO, (k == 3) ? v : '0, "store zero");
      end
      wr(WRDL_A_GRPSEL, 36'h1);
      fv = 16'(rnd());
      for (int i = 0; i < 16; i++)
         if (fv[i]) wr(WRDL_A_FLAGOP, fop(WRDL_FOP_SET, i));
      rd(WRDL_A_FLAG2, 36'(fv), "group two");
      for (int i = 0; i < 16; i++) begin
         wr(WRDL_A_FLAGOP, fop(WRDL_FOP_TEST, i));
         step(1);
         chk("flag_test_ff", 36'(fv[i]), 36'(flag_test_ff));
         if (fv[i]) wr(WRDL_A_FLAGOP, fop(WRDL_FOP_CLEAR, i));
      end
      rd(WRDL_A_FLAG2, '0, "group two clear");
      wr(WRDL_A_GRPSEL, '0);
      sg = 7'(rnd());
      for (int i = 0; i < 7; i++)
         if (sg[i]) wr(WRDL_A_FLAGOP, fop(WRDL_FOP_SET, i + 1));
      @(posedge clk_sys);
      long_timer_evt <= 1'b1;
      short_timer_evt <= 1'b1;
      @(posedge clk_sys);
      long_timer_evt <= 1'b0;
      short_timer_evt <= 1'b0;
      step(1);
      chk("segment_h", 36'(sg), 36'(segment_h));
      rd(WRDL_A_FLAG1, 36'({ext_val, 4'hC, sg, 1'b0}), "group one");
      rd(WRDL_A_FLAG2, '0, "group two kept");
      // Every analog select code, with the direction latch left at input
      for (int k = 0; k < 8; k++) begin
         d = 14'(rnd()) & 14'h30FF;
         d[11:9] = {k[0], k[1], k[2]};
         {eeprom_clock_drive, eeprom_power_drive, sensor_supply_on} <= 3'(rnd());
         {tick_1hz, tick_16hz} <= 2'(rnd());
         wr(WRDL_A_DL, 36'(d));
         step(2);
         chk("general_outputs", 36'(d[6:1]), 36'(general_outputs));
         chk("eeprom_clock_out", 36'(eeprom_clock_drive),
             36'(eeprom_clock_out));
         chk("eeprom_power_out", 36'(eeprom_power_drive),
             36'(eeprom_power_out));
         chk("analog_route", 36'(exp_route(d)), 36'(analog_route));
         chk("battery_check", 36'(d[9]), 36'(battery_check));
         chk("timer_tick", 36'(d[12] ? tick_16hz : tick_1hz),
             36'(timer_tick));
         chk("current_source_on", 36'(d[13] & sensor_supply_on),
             36'(current_source_on));
         rd(WRDL_A_DL, 36'({d[13:8], eeprom_power_drive, d[6:1],
            eeprom_clock_drive}), "digit latches");
      end
      kv = 4'(rnd());
      wr(WRDL_A_KOUT, 36'(kv));
      step(1);
      chk("port_oe input", '0, 36'(port_oe));
      rd(WRDL_A_KIN, 36'(ext_val), "port in");
      ext_en <= 1'b0;
      wr(WRDL_A_DL, 36'h100);
      step(2);
      chk("port_oe", 36'(kv), 36'(port_oe));
      chk("port_o", 36'hF, 36'(port_o));
      wr(WRDL_A_DL, '0);
      step(2);
      chk("port_oe off", '0, 36'(port_oe));
      ext_en <= 1'b1;
      rd(WRDL_A_KOUT, 36'(kv), "port latch kept");
      low_power <= 1'b1;
      step(3);
      w = 1'b0;
      chk("wake_up idle", '0, 36'(wake_up));
      ext_val <= ~ext_val;
      repeat (6) begin
         step(1);
         w |= wake_up;
      end
      chk("wake_up", 36'h1, 36'(w));
      low_power <= 1'b0;
      close_out();
   end
endmodule
